/* dipt_regs.vh */
// Constants for the dual interval process timer: register map, fields, timing.
// Assumes a 125 MHz clock and an APB slave with one aligned 32-bit word per register.
`ifndef DIPT_REGS_VH
`define DIPT_REGS_VH

`define DIPT_A_CTRL 8'h00
`define DIPT_A_MAIN_IV 8'h04
`define DIPT_A_TRAIL_IV 8'h08
`define DIPT_A_MAIN_CNT 8'h0C
`define DIPT_A_TRAIL_CNT 8'h10
`define DIPT_A_IRQ_STAT 8'h14
`define DIPT_A_IRQ_MASK 8'h18
`define DIPT_A_STATE 8'h1C

`define DIPT_CTRL_W 7
`define DIPT_CTRL_RST 7'h00
`define DIPT_F_MODE 1:0
`define DIPT_B_DIR 2
`define DIPT_B_BASE 3
`define DIPT_B_END_ON 4
`define DIPT_B_KEEP_RUN 5
`define DIPT_B_SHOW 6

`define DIPT_MODE_OFF 2'h0
`define DIPT_MODE_SETPOINT 2'h1
`define DIPT_MODE_KEY 2'h2
`define DIPT_MODE_RUN 2'h3

`define DIPT_F_HI 14:8
`define DIPT_F_LO 5:0
`define DIPT_HI_MAX 7'h63
`define DIPT_LO_MAX 6'h3B
`define DIPT_HI_ZERO 7'h00
`define DIPT_LO_ZERO 6'h00
`define DIPT_HI_ONE 7'h01
`define DIPT_LO_ONE 6'h01

`define DIPT_F_STATE 4:0
`define DIPT_B_ST_MAIN_OUT 8
`define DIPT_B_ST_TRAIL_OUT 9

`define DIPT_IRQ_N 4
`define DIPT_IRQ_RST 4'h0
`define DIPT_IRQ_START 0
`define DIPT_IRQ_EXPIRE 1
`define DIPT_IRQ_DONE 2
`define DIPT_IRQ_STOP 3

`define DIPT_CLK_HZ 125000000
`define DIPT_TICK_SEC 1
// One second of CLK cycles at DIPT_CLK_HZ
`define DIPT_SEC_CYCLES 27'h7735940
`define DIPT_PRE_W 27
`define DIPT_PRE_ZERO 27'h0000000
`define DIPT_PRE_ONE 27'h0000001
`define DIPT_MIN_LAST 6'h3B
`define DIPT_MIN_ZERO 6'h00
`define DIPT_MIN_ONE 6'h01

`endif

/* dipt_mmss.v */
// Two-field time counter: upper field 0..99, lower field 0..59.
// Assumes the caller never steps past 00:00 downward or 99:59 upward.
`timescale 1ns/1ns
`include "dipt_regs.vh"
module dipt_mmss (
   input wire clk,
   input wire rst,
   input wire ce,
   input wire load,
   input wire up,
   input wire step,
   input wire [6:0] load_hi,
   input wire [5:0] load_lo,
   output reg [6:0] hi_r,
   output reg [5:0] lo_r
);
   always @(posedge clk) begin
      if (rst) begin
         hi_r <= `DIPT_HI_ZERO;
         lo_r <= `DIPT_LO_ZERO;
      end else if (ce) begin
         if (load) begin
            hi_r <= load_hi;
            lo_r <= load_lo;
         end else if (step && up) begin
            if (lo_r == `DIPT_LO_MAX) begin
               lo_r <= `DIPT_LO_ZERO;
               hi_r <= (hi_r == `DIPT_HI_MAX) ? `DIPT_HI_ZERO : hi_r + `DIPT_HI_ONE;
            end else begin
               lo_r <= lo_r + `DIPT_LO_ONE;
            end
         end else if (step) begin
            if (lo_r == `DIPT_LO_ZERO) begin
               lo_r <= `DIPT_LO_MAX;
               hi_r <= (hi_r == `DIPT_HI_ZERO) ? `DIPT_HI_ZERO : hi_r - `DIPT_HI_ONE;
            end else begin
               lo_r <= lo_r - `DIPT_LO_ONE;
            end
         end
      end
   end
endmodule

/* dipt_timer.v */
// Dual interval process timer with APB register access and one interrupt line.
// Assumes PROCESS_VALUE, SETPOINT_VALUE, RUN_FLAG and KEY_PRESS are synchronous to CLK.
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ns
`include "dipt_regs.vh"
module dipt_timer #(
   parameter [26:0] SEC_CYCLES = `DIPT_SEC_CYCLES
) (
   input wire CLK,
   input wire RST,
   input wire CE,
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [7:0] PADDR,
   input wire [31:0] PWDATA,
   output reg [31:0] PRDATA,
   output reg PREADY,
   output reg PSLVERR,
   input wire [15:0] PROCESS_VALUE,
   input wire [15:0] SETPOINT_VALUE,
   input wire RUN_FLAG,
   input wire KEY_PRESS,
   output reg MAIN_OUT,
   output reg TRAIL_OUT,
   output reg RUN_CLR,
   output reg IRQ
);
   localparam [4:0] ST_IDLE = 5'h01;
   localparam [4:0] ST_MAIN = 5'h02;
   localparam [4:0] ST_HOLD = 5'h04;
   localparam [4:0] ST_TRAIL = 5'h08;
   localparam [4:0] ST_DONE = 5'h10;
   localparam [26:0] PRE_LAST = SEC_CYCLES - `DIPT_PRE_ONE;

   function [6:0] sat_hi;
      input [6:0] v;
      begin
         sat_hi = (v > `DIPT_HI_MAX) ? `DIPT_HI_MAX : v;
      end
   endfunction

   function [5:0] sat_lo;
      input [5:0] v;
      begin
         sat_lo = (v > `DIPT_LO_MAX) ? `DIPT_LO_MAX : v;
      end
   endfunction

   reg [`DIPT_CTRL_W-1:0] ctrl_r;
   reg [6:0] main_hi_r;
   reg [5:0] main_lo_r;
   reg [6:0] trail_hi_r;
   reg [5:0] trail_lo_r;
   reg [4:0] state_r;
   reg [4:0] state_nxt;
   reg [26:0] pre_r;
   reg [5:0] min_r;
   reg reached_r;
   reg run_prev_r;
   reg key_prev_r;
   reg [`DIPT_IRQ_N-1:0] irq_stat_r;
   reg [`DIPT_IRQ_N-1:0] irq_mask_r;
   reg [`DIPT_IRQ_N-1:0] ev_nxt;
   reg m_load;
   reg m_step;
   reg t_load;
   reg t_step;
   reg main_out_nxt;
   reg trail_out_nxt;
   reg run_clr_nxt;
   reg [31:0] rd_nxt;
   reg hit;

   wire [6:0] mc_hi;
   wire [5:0] mc_lo;
   wire [6:0] tc_hi;
   wire [5:0] tc_lo;
   wire [1:0] mode = ctrl_r[`DIPT_F_MODE];
   wire off = (mode == `DIPT_MODE_OFF);
   wire dir_down = ctrl_r[`DIPT_B_DIR];
   wire base_min = ctrl_r[`DIPT_B_BASE];
   wire reached = ($signed(PROCESS_VALUE) >= $signed(SETPOINT_VALUE));
   wire start_ev = ((mode == `DIPT_MODE_SETPOINT) && reached && !reached_r) ||
      ((mode == `DIPT_MODE_RUN) && RUN_FLAG && !run_prev_r);
   wire key_ev = (mode == `DIPT_MODE_KEY) && KEY_PRESS && !key_prev_r;
   wire timing = (state_r == ST_MAIN) || (state_r == ST_TRAIL);
   wire sec_tick = timing && (pre_r == PRE_LAST);
   wire tick = base_min ? (sec_tick && (min_r == `DIPT_MIN_LAST)) : sec_tick;
   wire main_done = dir_down ? ({mc_hi, mc_lo} == {`DIPT_HI_ZERO, `DIPT_LO_ZERO}) :
      ({mc_hi, mc_lo} >= {main_hi_r, main_lo_r});
   wire trail_zero = ({trail_hi_r, trail_lo_r} == {`DIPT_HI_ZERO, `DIPT_LO_ZERO});
   wire trail_one = ({tc_hi, tc_lo} == {`DIPT_HI_ZERO, `DIPT_LO_ONE});
   wire apb_acc = PSEL && PENABLE && !PREADY;
   wire apb_end = PSEL && PENABLE && PREADY;
   wire wr = apb_end && PWRITE && hit;
   wire stat_clr = apb_end && !PWRITE && (PADDR == `DIPT_A_IRQ_STAT);
   wire [6:0] m_load_hi = dir_down ? main_hi_r : `DIPT_HI_ZERO;
   wire [5:0] m_load_lo = dir_down ? main_lo_r : `DIPT_LO_ZERO;

   dipt_mmss u_main (
      .clk(CLK),
      .rst(RST),
      .ce(CE),
      .load(m_load),
      .up(!dir_down),
      .step(m_step),
      .load_hi(m_load_hi),
      .load_lo(m_load_lo),
      .hi_r(mc_hi),
      .lo_r(mc_lo)
   );

   dipt_mmss u_trail (
      .clk(CLK),
      .rst(RST),
      .ce(CE),
      .load(t_load),
      .up(1'b0),
      .step(t_step),
      .load_hi(trail_hi_r),
      .load_lo(trail_lo_r),
      .hi_r(tc_hi),
      .lo_r(tc_lo)
   );

   always @* begin
      state_nxt = state_r;
      m_load = 1'b0;
      m_step = 1'b0;
      t_load = 1'b0;
      t_step = 1'b0;
      main_out_nxt = MAIN_OUT;
      trail_out_nxt = TRAIL_OUT;
      run_clr_nxt = 1'b0;
      ev_nxt = `DIPT_IRQ_RST;
      if (off) begin
         state_nxt = ST_IDLE;
         main_out_nxt = 1'b0;
         trail_out_nxt = 1'b0;
      end else begin
         case (state_r)
            ST_IDLE, ST_DONE, ST_HOLD: begin
               if (start_ev || key_ev) begin
                  state_nxt = ST_MAIN;
                  m_load = 1'b1;
                  main_out_nxt = !ctrl_r[`DIPT_B_END_ON];
                  trail_out_nxt = 1'b0;
                  ev_nxt[`DIPT_IRQ_START] = 1'b1;
               end
            end
            ST_MAIN: begin
               if (key_ev) begin
                  state_nxt = ST_HOLD;
                  ev_nxt[`DIPT_IRQ_STOP] = 1'b1;
               end else if (main_done) begin
                  main_out_nxt = ctrl_r[`DIPT_B_END_ON];
                  ev_nxt[`DIPT_IRQ_EXPIRE] = 1'b1;
                  if (trail_zero) begin
                     state_nxt = ST_DONE;
                     ev_nxt[`DIPT_IRQ_DONE] = 1'b1;
                     run_clr_nxt = !ctrl_r[`DIPT_B_KEEP_RUN];
                  end else begin
                     state_nxt = ST_TRAIL;
                     t_load = 1'b1;
                     trail_out_nxt = 1'b1;
                  end
               end else if (tick) begin
                  m_step = 1'b1;
               end
            end
            ST_TRAIL: begin
               if (tick && trail_one) begin
                  state_nxt = ST_DONE;
                  trail_out_nxt = 1'b0;
                  ev_nxt[`DIPT_IRQ_DONE] = 1'b1;
                  run_clr_nxt = !ctrl_r[`DIPT_B_KEEP_RUN];
               end else if (tick) begin
                  t_step = 1'b1;
               end
            end
            default: begin
               state_nxt = ST_IDLE;
            end
         endcase
      end
   end

   always @* begin
      rd_nxt = 32'h00000000;
      hit = 1'b1;
      case (PADDR)
         `DIPT_A_CTRL: rd_nxt[`DIPT_CTRL_W-1:0] = ctrl_r;
         `DIPT_A_MAIN_IV: begin
            if (!off) begin
               rd_nxt[`DIPT_F_HI] = main_hi_r;
               rd_nxt[`DIPT_F_LO] = main_lo_r;
            end
         end
         `DIPT_A_TRAIL_IV: begin
            if (!off) begin
               rd_nxt[`DIPT_F_HI] = trail_hi_r;
               rd_nxt[`DIPT_F_LO] = trail_lo_r;
            end
         end
         `DIPT_A_MAIN_CNT: begin
            if (!off) begin
               rd_nxt[`DIPT_F_HI] = mc_hi;
               rd_nxt[`DIPT_F_LO] = mc_lo;
            end
         end
         `DIPT_A_TRAIL_CNT: begin
            if (!off) begin
               rd_nxt[`DIPT_F_HI] = tc_hi;
               rd_nxt[`DIPT_F_LO] = tc_lo;
            end
         end
         `DIPT_A_IRQ_STAT: rd_nxt[`DIPT_IRQ_N-1:0] = irq_stat_r;
         `DIPT_A_IRQ_MASK: rd_nxt[`DIPT_IRQ_N-1:0] = irq_mask_r;
         `DIPT_A_STATE: begin
            rd_nxt[`DIPT_F_STATE] = state_r;
            rd_nxt[`DIPT_B_ST_MAIN_OUT] = MAIN_OUT;
            rd_nxt[`DIPT_B_ST_TRAIL_OUT] = TRAIL_OUT;
         end
         default: hit = 1'b0;
      endcase
   end

   always @(posedge CLK) begin
      if (RST) begin
         state_r <= ST_IDLE;
         MAIN_OUT <= 1'b0;
         TRAIL_OUT <= 1'b0;
         RUN_CLR <= 1'b0;
         reached_r <= 1'b0;
         run_prev_r <= 1'b0;
         key_prev_r <= 1'b0;
         pre_r <= `DIPT_PRE_ZERO;
         min_r <= `DIPT_MIN_ZERO;
      end else if (CE) begin
         state_r <= state_nxt;
         MAIN_OUT <= main_out_nxt;
         TRAIL_OUT <= trail_out_nxt;
         RUN_CLR <= run_clr_nxt;
         reached_r <= reached;
         run_prev_r <= RUN_FLAG;
         key_prev_r <= KEY_PRESS;
         // Restart tick phase so each interval counts whole ticks
         if (m_load || t_load || !timing) begin
            pre_r <= `DIPT_PRE_ZERO;
            min_r <= `DIPT_MIN_ZERO;
         end else if (sec_tick) begin
            pre_r <= `DIPT_PRE_ZERO;
            min_r <= (min_r == `DIPT_MIN_LAST) ? `DIPT_MIN_ZERO : min_r + `DIPT_MIN_ONE;
         end else begin
            pre_r <= pre_r + `DIPT_PRE_ONE;
         end
      end
   end

   always @(posedge CLK) begin
      if (RST) begin
         ctrl_r <= `DIPT_CTRL_RST;
         main_hi_r <= `DIPT_HI_ZERO;
         main_lo_r <= `DIPT_LO_ZERO;
         trail_hi_r <= `DIPT_HI_ZERO;
         trail_lo_r <= `DIPT_LO_ZERO;
         irq_mask_r <= `DIPT_IRQ_RST;
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA <= 32'h00000000;
         IRQ <= 1'b0;
      end else if (CE) begin
         PREADY <= apb_acc;
         PSLVERR <= apb_acc && !hit;
         if (apb_acc && !PWRITE) begin
            PRDATA <= rd_nxt;
         end
         if (wr && (PADDR == `DIPT_A_CTRL)) begin
            ctrl_r <= PWDATA[`DIPT_CTRL_W-1:0];
         end
         // Interval settings are hidden and locked while timers are off
         if (wr && !off && (PADDR == `DIPT_A_MAIN_IV)) begin
            main_hi_r <= sat_hi(PWDATA[`DIPT_F_HI]);
            main_lo_r <= sat_lo(PWDATA[`DIPT_F_LO]);
         end
         if (wr && !off && (PADDR == `DIPT_A_TRAIL_IV)) begin
            trail_hi_r <= sat_hi(PWDATA[`DIPT_F_HI]);
            trail_lo_r <= sat_lo(PWDATA[`DIPT_F_LO]);
         end
         if (wr && (PADDR == `DIPT_A_IRQ_MASK)) begin
            irq_mask_r <= PWDATA[`DIPT_IRQ_N-1:0];
         end
         IRQ <= |(irq_stat_r & irq_mask_r);
      end
   end

   // Sticky event bits; a new event wins over the read clear
   // Only bits returned by the read are cleared, so a late event is not lost
   genvar gi;
   generate
      for (gi = 0; gi < `DIPT_IRQ_N; gi = gi + 1) begin : g_irq
         always @(posedge CLK) begin
            if (RST) begin
               irq_stat_r[gi] <= 1'b0;
            end else if (CE) begin
               irq_stat_r[gi] <= ev_nxt[gi] || (irq_stat_r[gi] && !(stat_clr && PRDATA[gi]));
            end
         end
      end
   endgenerate
endmodule

/* dipt_props.sv */
// Port assertions for the dual interval process timer.
// Assumes CE is low only while the bus is idle; SEC_CYCLES matches the design instance.
`timescale 1ns/1ns
module dipt_props #(
   parameter [26:0] SEC_CYCLES = 27'h4
) (
   input wire CLK,
   input wire RST,
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [7:0] PADDR,
   input wire [31:0] PWDATA,
   input wire PREADY,
   input wire PSLVERR,
   input wire RUN_FLAG,
   input wire MAIN_OUT,
   input wire TRAIL_OUT,
   input wire RUN_CLR
);
   logic [1:0] mode_r;
   logic end_r;
   logic [26:0] tcnt_r;
   default clocking @(posedge CLK);
   endclocking
   default disable iff (RST);
   // Shadow of mode and end state
   always @(posedge CLK) begin
      if (RST) begin
         mode_r <= 2'h0;
         end_r <= 1'b0;
      end else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == 8'h00) begin
         mode_r <= PWDATA[1:0];
         end_r <= PWDATA[4];
      end
      tcnt_r <= (RST || !TRAIL_OUT) ? 27'h0 : tcnt_r + 27'h1;
   end
   sequence setup_s;
      PSEL && !PENABLE;
   endsequence
   sequence access_s;
      PSEL && PENABLE;
   endsequence
   sequence off_held_s;
      mode_r == 2'h0 ##1 mode_r == 2'h0;
   endsequence
   AST_READY_SECOND: assert property (setup_s ##1 access_s |-> !PREADY ##1 PREADY)
      else $error("ready not in second access cycle");
   AST_UNMAPPED: assert property (access_s ##0 (PREADY && PADDR > 8'h1C) |-> PSLVERR)
      else $error("unmapped access without error");
   AST_OFF_QUIET: assert property (off_held_s |-> !MAIN_OUT && !TRAIL_OUT)
      else $error("output active in off mode");
   AST_RUN_START: assert property (mode_r == 2'h3 && $rose(RUN_FLAG) && !TRAIL_OUT |=>
      MAIN_OUT == !end_r)
      else $error("run flag did not start timer");
   AST_END_STATE: assert property ($rose(TRAIL_OUT) |-> MAIN_OUT == end_r)
      else $error("main output wrong at expiry");
   AST_TRAIL_SPAN: assert property ($fell(TRAIL_OUT) && mode_r != 2'h0 |->
      tcnt_r >= SEC_CYCLES)
      else $error("trailing output too short");
   AST_CLR_PULSE: assert property (RUN_CLR |=> !RUN_CLR)
      else $error("run clear longer than one cycle");
   AST_CLR_AFTER: assert property (RUN_CLR |-> !TRAIL_OUT && mode_r != 2'h0)
      else $error("run clear before trailing end");
endmodule
bind dipt_timer dipt_props #(.SEC_CYCLES(SEC_CYCLES)) dipt_props_i (.CLK(CLK), .RST(RST),
   .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
   .PREADY(PREADY), .PSLVERR(PSLVERR), .RUN_FLAG(RUN_FLAG), .MAIN_OUT(MAIN_OUT),
   .TRAIL_OUT(TRAIL_OUT), .RUN_CLR(RUN_CLR));

/* dipt_loop_model.sv */
// Stand-in for the control loop and the operator key.
// Assumes tasks are called right after a rising clk edge.
`timescale 1ns/1ns
module dipt_loop_model (
   input wire clk,
   output logic [15:0] process_value,
   output logic [15:0] setpoint_value,
   output logic run_flag,
   output logic key_press
);
   initial begin
      process_value = 16'h0000;
      setpoint_value = 16'h7FFF;
      run_flag = 1'b0;
      key_press = 1'b0;
   end
   task press();
      key_press <= 1'b1;
      @(posedge clk);
      key_press <= 1'b0;
      @(posedge clk);
   endtask
   task level(input logic [15:0] p, input logic [15:0] s, input logic r);
      process_value <= p;
      setpoint_value <= s;
      run_flag <= r;
      @(posedge clk);
   endtask
endmodule

/* tb_top.sv */
// Self-checking bench for the dual interval process timer.
// Assumes SEC_CYCLES of 4; cycle counts follow from it.
`timescale 1ns/1ns
module tb_top;
   logic clk, rst, ce, psel, penable, pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata, seed, r;
   logic [15:0] s;
   wire [31:0] prdata;
   wire pready, pslverr, main_out, trail_out, run_clr, irq, run_flag, key_press;
   wire [15:0] process_value, setpoint_value;
   logic [32:0] expq[$];
   integer fails = 0, checked = 0, n;
   dipt_timer #(.SEC_CYCLES(27'h4)) dipt_timer_i (.CLK(clk), .RST(rst), .CE(ce),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PROCESS_VALUE(process_value),
      .SETPOINT_VALUE(setpoint_value),
      .RUN_FLAG(run_flag), .KEY_PRESS(key_press), .MAIN_OUT(main_out),
      .TRAIL_OUT(trail_out), .RUN_CLR(run_clr), .IRQ(irq));
   dipt_loop_model dipt_loop_model_i (.clk(clk), .process_value(process_value),
      .setpoint_value(setpoint_value), .run_flag(run_flag), .key_press(key_press));
   task chk(input logic [32:0] seen, input logic [32:0] exp);
      checked = checked + 1;
      if (seen !== exp) begin
         fails = fails + 1;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task results();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
      if (!w)
         expq.push_back(e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task wt(input logic lvl);
      n = 0;
      do begin
         @(posedge clk);
         n = n + 1;
      end while (trail_out !== lvl);
   endtask
   task wm(input logic lvl);
      n = 0;
      do begin
         @(posedge clk);
         n = n + 1;
      end while (main_out !== lvl);
   endtask
   // Read results against the oldest note
   always @(posedge clk)
      if (psel && penable && pready === 1'b1 && !pwrite)
         chk({pslverr, prdata}, expq.pop_front());
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      repeat (3000) @(posedge clk);
      fails = fails + 1;
      results();
   end
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      seed = 32'h08F9;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      apb(0, 8'h00, 0, 33'h0);
      apb(0, 8'h18, 0, 33'h0);
      apb(0, 8'h20, 0, 33'h1_0000_0000);
      apb(1, 8'h04, 32'h0102, 0);
      apb(0, 8'h04, 0, 33'h0);
      apb(1, 8'h00, 32'h13, 0);
      apb(1, 8'h04, 32'h0002, 0);
      apb(1, 8'h08, 32'h0001, 0);
      apb(1, 8'h18, 32'hF, 0);
      dipt_loop_model_i.level(16'h0, 16'h7FFF, 1'b1);
      wt(1'b1);
      chk(n, 10);
      chk(main_out, 1'b1);
      wt(1'b0);
      chk(n, 4);
      chk(run_clr, 1'b1);
      chk(irq, 1'b1);
      apb(0, 8'h14, 0, 33'h7);
      apb(0, 8'h1C, 0, 33'h110);
      apb(1, 8'h00, 32'h26, 0);
      apb(1, 8'h04, 32'h0103, 0);
      dipt_loop_model_i.press();
      dipt_loop_model_i.press();
      chk(main_out, 1'b1);
      apb(0, 8'h0C, 0, 33'h0103);
      apb(0, 8'h1C, 0, 33'h104);
      apb(0, 8'h14, 0, 33'h9);
      @(posedge clk);
      chk(irq, 1'b0);
      dipt_loop_model_i.press();
      apb(0, 8'h1C, 0, 33'h102);
      apb(1, 8'h00, 32'h0, 0);
      @(posedge clk);
      chk(main_out, 1'b0);
      r = $random(seed);
      s = r[15:0] & 16'h3FFE;
      dipt_loop_model_i.level(s, s | 16'h1, 1'b0);
      apb(1, 8'h00, 32'h01, 0);
      apb(1, 8'h04, 32'h0005, 0);
      apb(0, 8'h1C, 0, 33'h001);
      dipt_loop_model_i.level(s | 16'h1, s | 16'h1, 1'b0);
      apb(0, 8'h1C, 0, 33'h102);
      apb(1, 8'h00, 32'h0, 0);
      apb(1, 8'h00, 32'h3E, 0);
      apb(1, 8'h04, 32'h0001, 0);
      apb(1, 8'h08, 32'h0000, 0);
      dipt_loop_model_i.press();
      ce <= 1'b0;
      repeat (10) @(posedge clk);
      ce <= 1'b1;
      wm(1'b1);
      chk(n, 241);
      chk(run_clr, 1'b0);
      chk(trail_out, 1'b0);
      apb(0, 8'h0C, 0, 33'h0);
      apb(0, 8'h1C, 0, 33'h110);
      repeat (2) @(posedge clk);
      results();
   end
endmodule
